// ===== design/rlydrv_defines.svh
/*
 * Constants of the relay driver block: action codes, status bit positions,
 * timing figures and reset values.
 * Assumes a 40 MHz module clock.
 */
`ifndef RLYDRV_DEFINES_SVH
`define RLYDRV_DEFINES_SVH

`define RLYDRV_OP_READ_PHYS 8'h00
`define RLYDRV_OP_READ_PROG 8'h01
`define RLYDRV_OP_PROGRAM 8'h02
`define RLYDRV_OP_CLEAR_FLAGS 8'h03
`define RLYDRV_OP_RESET 8'h04
`define RLYDRV_STAT_DRIVER_FAULT_FLAG_BIT 6
`define RLYDRV_STAT_STREAM_ERROR_FLAG_BIT 7
`define RLYDRV_CLK_HZ 40000000
`define RLYDRV_SCAN_MS 2
`define RLYDRV_SCAN_CYCLES ((`RLYDRV_CLK_HZ / 1000) * `RLYDRV_SCAN_MS)
`define RLYDRV_FAULT_WDOG_CYCLES 1000000
`define RLYDRV_COMM_WDOG_DEFAULT 40000000
`define RLYDRV_OUT_RESET 8'h00

`endif

// ===== design/rlydrv_pkg.sv
/*
 * Types of the relay driver block.
 * Assumes rlydrv_defines.svh is included by the modules.
 */
package rlydrv_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] data;
    } rlydrv_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rlydrv_rsp_t;

    typedef enum logic [1:0] {
        RLYDRV_IDLE = 2'b00,
        RLYDRV_SHIFT = 2'b01,
        RLYDRV_CHECK = 2'b11
    } rlydrv_scan_t;
endpackage : rlydrv_pkg

// ===== design/rlydrv_sync.sv
/*
 * Three-stage synchroniser for the monitored driver levels.
 * Assumes the inputs are asynchronous to CLK.
 */
`timescale 1ns/1ps
module rlydrv_sync #(
    parameter int WIDTH = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit only changes once the last two stages agree
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : rlydrv_sync

// ===== design/rlydrv_top.sv
/*
 * Relay coil driver control and fault status for eight channels.
 * Requests arrive already decoded from the serial link as one-cycle
 * strobes; the monitor levels arrive from the field side unsynchronised.
 */
// Contract
// - Eight coil driver channels, numbered 0 to 7
// - Drivers active low, open collector
// - Physical driver levels sampled for the client
// - Any module reset turns all drivers off
// - Reset on power-up, client request, fault watchdog
// - Reset when communication watchdog interval expires
// - Two module fault flags in status
// - Driver fault flag on commanded-state mismatch
// - Stream error flag on serial stream error
// - Clear-flags action clears both fault flags
// - Program outputs answers now, applies within 2 ms
// - Physical states sampled every 2 ms, returned
// - Read programmed states returns one byte
`timescale 1ns/1ps
`include "rlydrv_defines.svh"
module rlydrv_top #(
    parameter int NCH = 8,
    parameter int SCAN_CYCLES = `RLYDRV_SCAN_CYCLES,
    parameter int FAULT_WDOG_CYCLES = `RLYDRV_FAULT_WDOG_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire rlydrv_pkg::rlydrv_req_t REQ,
    output rlydrv_pkg::rlydrv_rsp_t RSP,
    input wire logic [31:0] COMM_WDOG_CYCLES,
    input wire logic FW_ALIVE,
    input wire logic STREAM_ERR,
    input wire logic [NCH-1:0] MON_PIN,
    output logic [NCH-1:0] DRV_OE_N,
    output logic [7:0] STATUS,
    output logic MODULE_RESET
);
    // ------------------------------------------------------------
    // Module reset sources
    // ------------------------------------------------------------
    logic req_prog, req_rd_phys, req_rd_prog, req_clear, req_reset;
    logic [31:0] comm_cnt_q;
    logic [31:0] fault_cnt_q;
    logic comm_to, fault_to, soft_rst_q;

    assign req_prog = REQ.valid && REQ.opcode == `RLYDRV_OP_PROGRAM;
    assign req_rd_phys = REQ.valid && REQ.opcode == `RLYDRV_OP_READ_PHYS;
    assign req_rd_prog = REQ.valid && REQ.opcode == `RLYDRV_OP_READ_PROG;
    assign req_clear = REQ.valid && REQ.opcode == `RLYDRV_OP_CLEAR_FLAGS;
    assign req_reset = REQ.valid && REQ.opcode == `RLYDRV_OP_RESET;

    assign comm_to = COMM_WDOG_CYCLES != '0 && comm_cnt_q >= COMM_WDOG_CYCLES - 32'h1;
    assign fault_to = fault_cnt_q >= 32'(FAULT_WDOG_CYCLES - 1);

    // Registered so the reset pulse is glitch free and one cycle long
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= !soft_rst_q && (req_reset || comm_to || fault_to);
        end
    end
    assign MODULE_RESET = soft_rst_q;

    // Any request restarts the communication watchdog
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            comm_cnt_q <= '0;
        end else if (REQ.valid || soft_rst_q) begin
            comm_cnt_q <= '0;
        end else if (!comm_to) begin
            comm_cnt_q <= comm_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            fault_cnt_q <= '0;
        end else if (FW_ALIVE || soft_rst_q) begin
            fault_cnt_q <= '0;
        end else if (!fault_to) begin
            fault_cnt_q <= fault_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Programmed and applied driver states
    // ------------------------------------------------------------
    logic [NCH-1:0] prog_q;
    logic [NCH-1:0] applied_q;
    logic [NCH-1:0] phys_q;
    logic [NCH-1:0] exp_q;
    logic [NCH-1:0] mon_sync;
    logic [31:0] scan_cnt_q;
    logic tick;
    rlydrv_pkg::rlydrv_scan_t scan_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            prog_q <= `RLYDRV_OUT_RESET;
        end else if (soft_rst_q) begin
            prog_q <= `RLYDRV_OUT_RESET;
        end else if (req_prog) begin
            prog_q <= REQ.data[NCH-1:0];
        end
    end

    assign tick = scan_cnt_q >= 32'(SCAN_CYCLES - 1);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            scan_cnt_q <= '0;
        end else if (tick || soft_rst_q) begin
            scan_cnt_q <= '0;
        end else begin
            scan_cnt_q <= scan_cnt_q + 32'h1;
        end
    end

    // Update is deferred to the next scan tick, as on the real stream
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            scan_q <= rlydrv_pkg::RLYDRV_IDLE;
        end else if (soft_rst_q) begin
            scan_q <= rlydrv_pkg::RLYDRV_IDLE;
        end else begin
            unique case (scan_q)
                rlydrv_pkg::RLYDRV_IDLE: if (tick) scan_q <= rlydrv_pkg::RLYDRV_SHIFT;
                rlydrv_pkg::RLYDRV_SHIFT: scan_q <= rlydrv_pkg::RLYDRV_CHECK;
                rlydrv_pkg::RLYDRV_CHECK: scan_q <= rlydrv_pkg::RLYDRV_IDLE;
                default: scan_q <= rlydrv_pkg::RLYDRV_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            applied_q <= `RLYDRV_OUT_RESET;
        end else if (soft_rst_q) begin
            applied_q <= `RLYDRV_OUT_RESET;
        end else if (scan_q == rlydrv_pkg::RLYDRV_SHIFT) begin
            applied_q <= prog_q;
        end
    end

    // Low enable pulls the coil low and energises it
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_drv
            assign DRV_OE_N[g] = !applied_q[g];
        end
    endgenerate

    // Monitor pin reads low when the coil is pulled in
    rlydrv_sync #(.WIDTH(NCH)) u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .din(~MON_PIN),
        .dout(mon_sync)
    );

    // Monitor is judged against what was driven over the whole last scan,
    // so a fresh program change is never mistaken for a stuck driver
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            phys_q <= '0;
            exp_q <= `RLYDRV_OUT_RESET;
        end else if (scan_q == rlydrv_pkg::RLYDRV_SHIFT) begin
            phys_q <= mon_sync;
            exp_q <= applied_q;
        end
    end

    // ------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------
    logic driver_fault_flag_q, stream_error_flag_q, mismatch;
    assign mismatch = scan_q == rlydrv_pkg::RLYDRV_CHECK && phys_q != exp_q;

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            driver_fault_flag_q <= 1'b0;
        end else if (mismatch) begin
            driver_fault_flag_q <= 1'b1;
        end else if (req_clear || soft_rst_q) begin
            driver_fault_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            stream_error_flag_q <= 1'b0;
        end else if (STREAM_ERR) begin
            stream_error_flag_q <= 1'b1;
        end else if (req_clear || soft_rst_q) begin
            stream_error_flag_q <= 1'b0;
        end
    end

    always_comb begin
        STATUS = 8'h00;
        STATUS[`RLYDRV_STAT_DRIVER_FAULT_FLAG_BIT] = driver_fault_flag_q;
        STATUS[`RLYDRV_STAT_STREAM_ERROR_FLAG_BIT] = stream_error_flag_q;
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RSP <= '0;
        end else begin
            RSP.valid <= REQ.valid;
            if (req_rd_phys) begin
                RSP.data <= 8'(phys_q);
            end else if (req_rd_prog) begin
                RSP.data <= 8'(prog_q);
            end else begin
                RSP.data <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_prog_seen;
        req_prog && !soft_rst_q;
    endsequence

    a_reset_drv_off: assert property (@(posedge CLK) disable iff (!NRST)
        soft_rst_q |=> DRV_OE_N == '1) else $error("drivers not off after reset");
    a_req_reset_fire: assert property (@(posedge CLK) disable iff (!NRST)
        req_reset && !soft_rst_q |=> soft_rst_q) else $error("reset request ignored");
    a_prog_stored: assert property (@(posedge CLK) disable iff (!NRST)
        s_prog_seen |=> prog_q == $past(REQ.data)) else $error("program not stored");
    a_drv_applied: assert property (@(posedge CLK) disable iff (!NRST)
        scan_q == rlydrv_pkg::RLYDRV_SHIFT && !soft_rst_q |=> applied_q == $past(prog_q))
        else $error("program not applied on scan");
    a_rsp_next: assert property (@(posedge CLK) disable iff (!NRST)
        REQ.valid |=> RSP.valid) else $error("no response");
    a_rd_prog_data: assert property (@(posedge CLK) disable iff (!NRST)
        req_rd_prog |=> RSP.data == $past(prog_q)) else $error("wrong programmed read");
    a_driver_fault_flag_set: assert property (@(posedge CLK) disable iff (!NRST)
        mismatch |=> STATUS[`RLYDRV_STAT_DRIVER_FAULT_FLAG_BIT]) else $error("driver fault lost");
    a_stream_error_flag_set: assert property (@(posedge CLK) disable iff (!NRST)
        STREAM_ERR |=> STATUS[`RLYDRV_STAT_STREAM_ERROR_FLAG_BIT]) else $error("stream error lost");
    a_flags_clear: assert property (@(posedge CLK) disable iff (!NRST)
        req_clear && !mismatch && !STREAM_ERR |=> !driver_fault_flag_q && !stream_error_flag_q) else $error("flags not cleared");
    a_flags_sticky: assert property (@(posedge CLK) disable iff (!NRST)
        driver_fault_flag_q && !req_clear && !soft_rst_q |=> driver_fault_flag_q) else $error("driver flag dropped");
endmodule : rlydrv_top

// ===== test/rlydrv_coil_model.sv
/*
 * Field-side model of the eight coil drivers and their monitor taps.
 * Assumes the drivers are open collector with a pull-up on each monitor line.
 */
`timescale 1ns/1ps
module rlydrv_coil_model (
    input wire logic [7:0] DRV_OE_N,
    input wire logic [7:0] STUCK_MASK,
    output logic [7:0] MON_PIN
);
    // ----------------------------------------
    // Monitor levels
    // ----------------------------------------
    // An enabled driver pulls low, a released one floats up to the pull-up;
    // a set mask bit models a broken driver that reads the wrong level
    assign MON_PIN = DRV_OE_N ^ STUCK_MASK;
endmodule : rlydrv_coil_model

// ===== test/testbench.sv
/*
 * Self-checking bench of the relay driver block with shortened scan and
 * fault watchdog counts. Assumes the coil model stands on the field side.
 */
`timescale 1ns/1ps
`include "rlydrv_defines.svh"
module testbench;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    rlydrv_pkg::rlydrv_req_t req = '0;
    rlydrv_pkg::rlydrv_rsp_t rsp;
    logic [31:0] comm = 32'h0;
    logic fw = 1'b1;
    logic serr = 1'b0;
    logic [7:0] mask = 8'h00;
    logic [7:0] mon;
    logic [7:0] oe_n;
    logic [7:0] status;
    logic mreset;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    bit seen;
    always #12.5 clk = ~clk;
    rlydrv_top #(.NCH(8), .SCAN_CYCLES(16), .FAULT_WDOG_CYCLES(200)) i_rlydrv_top (
        .CLK(clk), .NRST(nrst), .REQ(req), .RSP(rsp), .COMM_WDOG_CYCLES(comm), .FW_ALIVE(fw),
        .STREAM_ERR(serr), .MON_PIN(mon), .DRV_OE_N(oe_n), .STATUS(status), .MODULE_RESET(mreset));
    rlydrv_coil_model i_rlydrv_coil_model (.DRV_OE_N(oe_n), .STUCK_MASK(mask), .MON_PIN(mon));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request goes up after a falling edge; the answer stands in the next cycle
    task automatic do_req(input logic [7:0] op, input logic [7:0] dat, input logic [7:0] exp);
        req <= '{valid: 1'b1, opcode: op, data: dat};
        @(negedge clk);
        req <= '0;
        chk("rsp valid", 8'h01, {7'h00, rsp.valid});
        chk("rsp data", exp, rsp.data);
        @(negedge clk);
    endtask : do_req
    task automatic wait_mr(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (mreset === 1'b1) begin
                seen = 1'b1;
            end
        end
    endtask : wait_mr
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_program();
        do_req(`RLYDRV_OP_PROGRAM, 8'hA5, 8'h00);
        repeat (24) @(negedge clk);
        chk("drivers", 8'h5A, oe_n);
        do_req(`RLYDRV_OP_READ_PROG, 8'h00, 8'hA5);
        repeat (40) @(negedge clk);
        do_req(`RLYDRV_OP_READ_PHYS, 8'h00, 8'hA5);
        chk("status clean", 8'h00, status);
        $display("test program done");
    endtask : t_program
    task automatic t_fault();
        mask <= 8'h01;
        repeat (40) @(negedge clk);
        chk("driver fault", 8'h01, {7'h00, status[`RLYDRV_STAT_DRIVER_FAULT_FLAG_BIT]});
        do_req(`RLYDRV_OP_READ_PHYS, 8'h00, 8'hA4);
        mask <= 8'h00;
        repeat (40) @(negedge clk);
        chk("fault sticky", 8'h01, {7'h00, status[`RLYDRV_STAT_DRIVER_FAULT_FLAG_BIT]});
        do_req(`RLYDRV_OP_CLEAR_FLAGS, 8'h00, 8'h00);
        chk("fault cleared", 8'h00, status);
        $display("test fault done");
    endtask : t_fault
    task automatic t_stream();
        serr <= 1'b1;
        @(negedge clk);
        serr <= 1'b0;
        repeat (2) @(negedge clk);
        chk("stream flag", 8'h01, {7'h00, status[`RLYDRV_STAT_STREAM_ERROR_FLAG_BIT]});
        repeat (30) @(negedge clk);
        chk("stream sticky", 8'h80, status);
        do_req(8'h3C, 8'h00, 8'h00);
        do_req(`RLYDRV_OP_CLEAR_FLAGS, 8'h00, 8'h00);
        chk("stream cleared", 8'h00, status);
        $display("test stream done");
    endtask : t_stream
    task automatic t_client_reset();
        serr <= 1'b1;
        @(negedge clk);
        serr <= 1'b0;
        // The reset pulse lasts one cycle, so it is looked at inline
        req <= '{valid: 1'b1, opcode: `RLYDRV_OP_RESET, data: 8'h00};
        @(negedge clk);
        req <= '0;
        chk("rsp valid", 8'h01, {7'h00, rsp.valid});
        chk("rsp data", 8'h00, rsp.data);
        chk("reset pulse", 8'h01, {7'h00, mreset});
        @(negedge clk);
        chk("drivers off", 8'hFF, oe_n);
        chk("flags reset", 8'h00, status);
        wait_mr(4);
        chk("single pulse", 8'h00, {7'h00, seen});
        do_req(`RLYDRV_OP_READ_PROG, 8'h00, 8'h00);
        $display("test client reset done");
    endtask : t_client_reset
    task automatic t_comm_wdog();
        do_req(`RLYDRV_OP_PROGRAM, 8'h3C, 8'h00);
        comm <= 32'h00000064;
        for (int i = 0; i < 4; i++) begin
            wait_mr(50);
            chk("no early reset", 8'h00, {7'h00, seen});
            do_req(`RLYDRV_OP_READ_PROG, 8'h00, 8'h3C);
        end
        wait_mr(130);
        chk("comm reset", 8'h01, {7'h00, seen});
        chk("drivers off", 8'hFF, oe_n);
        comm <= 32'h0;
        $display("test comm watchdog done");
    endtask : t_comm_wdog
    task automatic t_fault_wdog();
        do_req(`RLYDRV_OP_PROGRAM, 8'hFF, 8'h00);
        wait_mr(150);
        chk("kept alive", 8'h00, {7'h00, seen});
        fw <= 1'b0;
        wait_mr(260);
        chk("wdog reset", 8'h01, {7'h00, seen});
        chk("drivers off", 8'hFF, oe_n);
        fw <= 1'b1;
        $display("test fault watchdog done");
    endtask : t_fault_wdog
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    // Whole run needs about 960 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        chk("drivers at reset", 8'hFF, oe_n);
        chk("status at reset", 8'h00, status);
        nrst <= 1'b1;
        @(negedge clk);
        t_program();
        t_fault();
        t_stream();
        t_client_reset();
        t_comm_wdog();
        t_fault_wdog();
        give_verdict();
    end
endmodule : testbench
